// *** design/spi_port_config_control.sv ***
// spi port core: apb registers, master/slave shifter, tx and rx fifos
// assumes one 200 MHz core clock; pins are resolved by the surrounding pads
//
// Functional notes
// - three-wire makes data one shared line: master half-duplex, slave receive only
// - master phase bit selects advanced or delayed
// - polarity bit sets sck idle level, both modes
// - scale code picks sck rate from table
// - busy bit reads master engine activity
// - master bit writable only while engine idle
// - select output enable drives or floats select
// - zero delay field means manual select
// - nonzero delay times lead, trail, high gap
// - strobe bit emits bare clocks, master idle only
// - fifo init resets fifos, clears error flag
// - byte mode bit picks pio or block
// - full duplex cannot set under three-wire
// - manual select bit drives select low or high
// - read enable starts master read or slave receive
// - transmit ready reads fifo not full
// - receive ready reads data available, resets one
// - tx empty and rx full status bits
// - tx length zero means eight bits
// - rx length zero means eight bits
// - three interrupt enables, reset to zero
// - error flag on tx underflow, rx overflow
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`include "spi_port_regs.svh"
module spi_port_config_control (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output spi_port_pkg::pin_s sck,
  input wire logic sck_i,
  output spi_port_pkg::pin_s mosi,
  input wire logic mosi_i,
  output spi_port_pkg::pin_s miso,
  input wire logic miso_i,
  output spi_port_pkg::pin_s ss_n,
  input wire logic ss_n_i,
  output logic spi_irq
);
  // half sck period in core cycles for a scale code, rounded down
  function automatic logic [9:0] half_cycles(input logic [3:0] code);
    logic [31:0] khz;
    khz = 32'd250;
    unique case (code)
      4'h0: khz = 32'd12000;
      4'h1: khz = 32'd8000;
      4'h2: khz = 32'd6000;
      4'h3: khz = 32'd4000;
      4'h4: khz = 32'd3000;
      4'h5: khz = 32'd2000;
      4'h6: khz = 32'd1500;
      4'h7: khz = 32'd1000;
      4'h8: khz = 32'd750;
      4'h9: khz = 32'd500;
      4'hA, 4'hC, 4'hE: khz = 32'd375;
      4'hB, 4'hD, 4'hF: khz = 32'd250;
    endcase
    half_cycles = 10'(`SPI_CORE_KHZ / (2 * khz));
  endfunction

  // bit count of a length field, zero meaning a full byte
  function automatic logic [3:0] len_bits(input logic [2:0] len);
    len_bits = (len == 3'h0) ? 4'h8 : {1'b0, len};
  endfunction

  spi_port_pkg::cfg_s cfg; // busy field unused, read from engine
  localparam logic [15:0] cfg_rst_word = `SPI_CFG_RST; // bit 8 has no flop
  logic byte_mode, fdx, ss_man, rd_en;
  logic [2:0] tx_len, rx_len, ien;
  logic [2:0] flags; // rx, tx, block
  logic ferr, strobe_req, fifo_init, rx_boot;
  spi_port_pkg::eng_e st;
  logic [9:0] hcnt;
  logic [4:0] dcnt, ecnt;
  logic [3:0] nbits;
  logic strobing, rd_xfer, wr_xfer;
  logic [7:0] tsh, rsh;
  logic rx_push, tx_pop;
  logic [7:0] rx_byte;
  logic [2:0] sync1, sync2, sync3; // sck, mosi, ss_n
  logic [3:0] scnt;

  // fifo storage and pointers, one spare pointer bit for full
  logic [7:0] txm [`SPI_FIFO_DEPTH];
  logic [7:0] rxm [`SPI_FIFO_DEPTH];
  logic [`SPI_PTR_W-1:0] txw, txr, rxw, rxr;
  logic tx_empty, tx_full, rx_empty, rx_full;
  assign tx_empty = (txw == txr);
  assign rx_empty = (rxw == rxr);
  assign tx_full = (txw[1:0] == txr[1:0]) && (txw[2] != txr[2]);
  assign rx_full = (rxw[1:0] == rxr[1:0]) && (rxw[2] != rxr[2]);

  // apb decode
  logic acc, wr, rd;
  logic [15:0] idx;
  assign idx = paddr[`SPI_ADDR_W-1:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = 1'b1; // zero wait states
  logic busy, fdx_eff, auto_ss;
  assign busy = (st != spi_port_pkg::ST_IDLE);
  assign fdx_eff = fdx && !cfg.three_wire;
  assign auto_ss = (cfg.ss_dly != 5'h00);
  logic dat_rd;
  assign dat_rd = rd && (idx == `SPI_IDX_DAT);

  // configuration register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= {cfg_rst_word[15:9], cfg_rst_word[7:0]};
    end else if (wr && idx == `SPI_IDX_CFG) begin
      cfg.three_wire <= pwdata[15];
      cfg.phase_adv <= pwdata[14];
      cfg.cpol_pos <= pwdata[13];
      cfg.scale <= pwdata[12:9];
      cfg.ss_oe <= pwdata[5];
      cfg.ss_dly <= pwdata[4:0];
      // mode held while a transfer runs
      if (!busy) begin
        cfg.master <= pwdata[`SPI_B_MASTER];
      end
    end
  end

  // control register, interrupt enables, command pulses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_mode <= 1'b0;
      fdx <= 1'b0;
      ss_man <= 1'b0;
      rd_en <= 1'b0;
      tx_len <= 3'h0;
      rx_len <= 3'h0;
      ien <= 3'h0;
      strobe_req <= 1'b0;
      fifo_init <= 1'b0;
    end else begin
      fifo_init <= 1'b0; // self clearing
      if (st == spi_port_pkg::ST_IDLE && cfg.master && strobe_req) begin
        strobe_req <= 1'b0; // taken by the engine
      end
      // read enable is sticky until the master read begins
      if (st == spi_port_pkg::ST_IDLE && cfg.master && !strobe_req && rd_en) begin
        rd_en <= 1'b0;
      end
      if (wr && idx == `SPI_IDX_CTL) begin
        byte_mode <= pwdata[`SPI_B_BYTE];
        fdx <= pwdata[`SPI_B_FDX] && !cfg.three_wire;
        ss_man <= pwdata[`SPI_B_SSMAN];
        rd_en <= pwdata[`SPI_B_RDEN];
        tx_len <= pwdata[5:3];
        rx_len <= pwdata[2:0];
        fifo_init <= pwdata[`SPI_B_FINIT];
        // strobe ignored in slave mode or while busy
        if (pwdata[`SPI_B_STROBE] && cfg.master && !busy) begin
          strobe_req <= 1'b1;
        end
      end
      if (wr && idx == `SPI_IDX_IEN) begin
        ien <= pwdata[2:0];
      end
    end
  end

  // transmit fifo; writes to a full fifo are dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txw <= '0;
      txr <= '0;
    end else if (fifo_init) begin
      txw <= '0;
      txr <= '0;
    end else begin
      if (wr && idx == `SPI_IDX_DAT && !tx_full) begin
        txm[txw[1:0]] <= pwdata[7:0];
        txw <= txw + 3'h1;
      end
      if (tx_pop && !tx_empty) begin
        txr <= txr + 3'h1;
      end
    end
  end

  // receive fifo; a push into a full fifo is lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxw <= '0;
      rxr <= '0;
    end else if (fifo_init) begin
      rxw <= '0;
      rxr <= '0;
    end else begin
      if (rx_push && !rx_full) begin
        rxm[rxw[1:0]] <= rx_byte;
        rxw <= rxw + 3'h1;
      end
      if (dat_rd && !rx_empty) begin
        rxr <= rxr + 3'h1;
      end
    end
  end

  // receive-ready reads one out of reset until first init or read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_boot <= 1'b1;
    end else if (fifo_init || dat_rd) begin
      rx_boot <= 1'b0;
    end
  end

  // fifo error; a new error in the init cycle still sets it
  logic tx_under;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ferr <= 1'b0;
    end else if ((rx_push && rx_full) || tx_under) begin
      ferr <= 1'b1;
    end else if (fifo_init) begin
      ferr <= 1'b0;
    end
  end

  // sticky event flags, set wins over clear
  logic ev_rx, ev_tx, ev_blk;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= 3'h0;
    end else begin
      if (ev_rx) flags[2] <= 1'b1;
      else if (dat_rd) flags[2] <= 1'b0;
      if (ev_tx) flags[1] <= 1'b1;
      else if (wr && idx == `SPI_IDX_CLR && pwdata[1]) flags[1] <= 1'b0;
      if (ev_blk) flags[0] <= 1'b1;
      else if (wr && idx == `SPI_IDX_CLR && pwdata[0]) flags[0] <= 1'b0;
    end
  end
  assign ev_rx = rx_push && byte_mode;
  assign ev_tx = tx_pop && byte_mode;

  // interrupt request from enabled flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_irq <= 1'b0;
    end else begin
      spi_irq <= |(flags & ien);
    end
  end

  // read data and error answer captured in the setup cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      unique case (paddr[`SPI_ADDR_W-1:2])
        `SPI_IDX_CFG: prdata[15:0] <= {cfg[14:8], 1'b0, busy, cfg[6:0]};
        // command bits always read zero
        `SPI_IDX_CTL: prdata[15:0] <= {2'b00, byte_mode, fdx, ss_man, rd_en,
          !tx_full, !rx_empty || rx_boot, tx_empty, rx_full, tx_len, rx_len};
        `SPI_IDX_IEN: prdata[2:0] <= ien;
        `SPI_IDX_STS: prdata[7:0] <= {ferr, 4'h0, flags};
        `SPI_IDX_CLR: prdata <= 32'h0;
        `SPI_IDX_DAT: prdata[7:0] <= rx_empty ? 8'h00 : rxm[rxr[1:0]];
        default: pslverr <= 1'b1; // unmapped word
      endcase
    end
  end

  // pin synchronisers: sck, mosi, ss_n
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 3'b100;
      sync2 <= 3'b100;
      sync3 <= 3'b100;
    end else begin
      sync1 <= {ss_n_i, mosi_i, sck_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic miso_s1, miso_s2;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
    end
  end

  // master data in: the shared line when three-wire
  logic m_din, tick, lead_edge, last_edge;
  assign m_din = cfg.three_wire ? sync2[1] : miso_s2;
  assign tick = (hcnt == 10'h0);
  assign lead_edge = !ecnt[0];
  assign last_edge = (ecnt == {nbits - 4'h1, 1'b1});
  logic m_start;
  assign m_start = cfg.master && (strobe_req || rd_en || !tx_empty);
  // slave edges from synced clock, polarity applied
  logic s_sel, s_lead, s_trail, s_rx, s_tx;
  assign s_sel = !cfg.master && !sync2[2];
  assign s_lead = s_sel && (sync2[0] != sync3[0]) && (sync2[0] == cfg.cpol_pos);
  assign s_trail = s_sel && (sync2[0] != sync3[0]) && (sync2[0] != cfg.cpol_pos);
  assign s_rx = rd_en || fdx_eff;
  assign s_tx = !rd_en || fdx_eff;

  // master engine: divider, select timing, shifting; slave shifter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= spi_port_pkg::ST_IDLE;
      hcnt <= 10'h0;
      dcnt <= 5'h0;
      ecnt <= 5'h0;
      nbits <= 4'h8;
      strobing <= 1'b0;
      rd_xfer <= 1'b0;
      wr_xfer <= 1'b0;
      tsh <= 8'hFF;
      rsh <= 8'h00;
      scnt <= 4'h0;
      rx_push <= 1'b0;
      tx_pop <= 1'b0;
      tx_under <= 1'b0;
      ev_blk <= 1'b0;
      rx_byte <= 8'h00;
      sck.o <= 1'b0;
      mosi.o <= 1'b1;
      miso.o <= 1'b1;
    end else begin
      rx_push <= 1'b0;
      tx_pop <= 1'b0;
      tx_under <= 1'b0;
      ev_blk <= 1'b0;
      hcnt <= tick ? half_cycles(cfg.scale) - 10'h1 : hcnt - 10'h1;
      unique case (st)
        spi_port_pkg::ST_IDLE: begin
          sck.o <= !cfg.cpol_pos; // idle level
          ecnt <= 5'h0;
          hcnt <= half_cycles(cfg.scale) - 10'h1;
          if (m_start) begin
            strobing <= strobe_req;
            rd_xfer <= !strobe_req && (rd_en || fdx_eff);
            rsh <= 8'h00; // partial bytes stay right-aligned
            wr_xfer <= !strobe_req && (!rd_en || fdx_eff);
            nbits <= strobe_req ? `SPI_STROBE_BITS :
              (rd_en && !fdx_eff) ? len_bits(rx_len) : len_bits(tx_len);
            // a write that finds no data sends ones and flags underflow
            tsh <= (strobe_req || (rd_en && !fdx_eff) || tx_empty) ? 8'hFF :
              txm[txr[1:0]];
            tx_under <= !strobe_req && fdx_eff && rd_en && tx_empty;
            tx_pop <= !strobe_req && (!rd_en || fdx_eff) && !tx_empty;
            dcnt <= cfg.ss_dly;
            st <= auto_ss ? spi_port_pkg::ST_LEAD : spi_port_pkg::ST_SHIFT;
          end
        end
        spi_port_pkg::ST_LEAD: begin
          // select low to first clock, in half bits
          if (tick) begin
            dcnt <= dcnt - 5'h1;
            if (dcnt == 5'h1) begin
              st <= spi_port_pkg::ST_SHIFT;
            end
          end
          // advanced phase puts the first bit out before any edge
          if (cfg.phase_adv && !strobing) begin
            mosi.o <= tsh[7];
          end
        end
        spi_port_pkg::ST_SHIFT: begin
          if (ecnt == 5'h0 && cfg.phase_adv && !strobing && !tick) begin
            mosi.o <= tsh[7];
          end
          if (tick) begin
            sck.o <= !sck.o;
            ecnt <= ecnt + 5'h1;
            if (!strobing) begin
              // sample on lead edge if advanced, else on trail
              if (lead_edge == cfg.phase_adv) begin
                rsh <= {rsh[6:0], m_din};
              end else begin
                mosi.o <= cfg.phase_adv ? tsh[6] : tsh[7];
                tsh <= {tsh[6:0], 1'b1};
              end
            end
            if (last_edge) begin
              dcnt <= cfg.ss_dly;
              st <= auto_ss ? spi_port_pkg::ST_TRAIL : spi_port_pkg::ST_IDLE;
              rx_push <= rd_xfer;
              rx_byte <= cfg.phase_adv ? rsh : {rsh[6:0], m_din};
              ev_blk <= !byte_mode && !strobing && tx_empty;
            end
          end
        end
        spi_port_pkg::ST_TRAIL: begin
          // last clock to select high
          if (tick) begin
            dcnt <= dcnt - 5'h1;
            if (dcnt == 5'h1) begin
              dcnt <= cfg.ss_dly;
              st <= spi_port_pkg::ST_GAP;
            end
          end
        end
        spi_port_pkg::ST_GAP: begin
          // least select high time
          if (tick) begin
            dcnt <= dcnt - 5'h1;
            if (dcnt == 5'h1) begin
              st <= spi_port_pkg::ST_IDLE;
            end
          end
        end
      endcase
      // slave: sample on leading edge, drive on trailing edge
      if (!cfg.master) begin
        if (sync2[2] && !sync3[2] || !s_sel) begin
          scnt <= 4'h0;
        end
        if (!sync2[2] && sync3[2] && s_tx) begin
          // select fell: load first byte
          tsh <= tx_empty ? 8'hFF : txm[txr[1:0]];
          miso.o <= tx_empty ? 1'b1 : txm[txr[1:0]][7];
          tx_pop <= !tx_empty;
          tx_under <= tx_empty;
        end
        if (s_lead) begin
          rsh <= {rsh[6:0], cfg.three_wire ? sync2[1] : sync2[1]};
          scnt <= scnt + 4'h1;
          if (scnt + 4'h1 == len_bits(s_rx && !s_tx ? rx_len : tx_len)) begin
            scnt <= 4'h0;
            rx_push <= s_rx;
            rx_byte <= {rsh[6:0], sync2[1]};
          end
        end
        if (s_trail && s_tx) begin
          if (scnt == 4'h0) begin
            // next byte of a continued frame
            tsh <= tx_empty ? 8'hFF : txm[txr[1:0]];
            miso.o <= tx_empty ? 1'b1 : txm[txr[1:0]][7];
            tx_pop <= !tx_empty;
            tx_under <= tx_empty;
          end else begin
            miso.o <= tsh[6];
            tsh <= {tsh[6:0], 1'b1};
          end
        end
      end
    end
  end

  // pin enables and select level
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck.oe <= 1'b0;
      mosi.oe <= 1'b0;
      miso.oe <= 1'b0;
      ss_n.o <= 1'b1;
      ss_n.oe <= 1'b0;
    end else begin
      sck.oe <= cfg.master;
      // shared line turns around during a half-duplex read
      mosi.oe <= cfg.master && !(cfg.three_wire && busy && rd_xfer);
      miso.oe <= s_sel && s_tx && !cfg.three_wire;
      ss_n.oe <= cfg.master && cfg.ss_oe;
      if (!auto_ss) begin
        ss_n.o <= !ss_man;
      end else begin
        ss_n.o <= !(st == spi_port_pkg::ST_LEAD || st == spi_port_pkg::ST_SHIFT ||
          st == spi_port_pkg::ST_TRAIL);
      end
    end
  end
endmodule

// *** design/spi_port_pkg.sv ***
// types shared by the spi port configuration and control core
// assumes the register header is included by the design file
package spi_port_pkg;
  // configuration register image
  typedef struct packed {
    logic three_wire;
    logic phase_adv;
    logic cpol_pos;
    logic [3:0] scale;
    logic busy;
    logic master;
    logic ss_oe;
    logic [4:0] ss_dly;
  } cfg_s;
  // master engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_TRAIL,
    ST_GAP
  } eng_e;
  // one pin in two signals, its input kept apart
  typedef struct packed {
    logic o;
    logic oe;
  } pin_s;
endpackage

// *** design/spi_port_regs.svh ***
// register map, field positions, reset values and timing counts
// assumes 32-bit apb, one register per word, byte address = 4 * index
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH
`define SPI_IDX_CFG 16'hC0C8
`define SPI_IDX_CTL 16'hC0CA
`define SPI_IDX_IEN 16'hC0CC
`define SPI_IDX_STS 16'hC0CE
`define SPI_IDX_CLR 16'hC0D0
`define SPI_IDX_DAT 16'hC0D6
`define SPI_ADDR_W 18
`define SPI_CFG_RST 16'h801F
`define SPI_CTL_RST 16'h0000
`define SPI_B_STROBE 15
`define SPI_B_FINIT 14
`define SPI_B_BYTE 13
`define SPI_B_FDX 12
`define SPI_B_SSMAN 11
`define SPI_B_RDEN 10
`define SPI_B_BUSY 7
`define SPI_B_MASTER 6
`define SPI_B_FERR 7
`define SPI_CORE_KHZ 200000
`define SPI_STROBE_BITS 4'h8
`define SPI_FIFO_DEPTH 4
`define SPI_PTR_W 3
`endif

// *** sim/spi_peer_model.sv ***
// peer model: a slave device on the far side of the port
// assumes select, clock and data levels are resolved by the bench
`timescale 1ns/100ps
module spi_peer_model (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic idle_lvl,
  input wire logic lead_smp,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] sh; // reply bits not yet sent
  initial begin
    miso = 1'h0;
    got = 8'h00;
    sh = 8'h00;
  end
  // new frame: load reply, first bit early when sampling on leading edge
  always @(negedge ss_n) begin
    sh = reply;
    got = 8'h00;
    if (lead_smp) begin
      miso = sh[7];
      sh = {sh[6:0], 1'h0};
    end
  end
  // released line must not keep its last value
  always @(posedge ss_n) miso = ~miso;
  // sample on one clock edge, drive on the other
  always @(sck) begin
    if (!ss_n && ((sck !== idle_lvl) == lead_smp)) got = {got[6:0], mosi};
    else if (!ss_n) begin
      miso = sh[7];
      sh = {sh[6:0], 1'h0};
    end
  end
endmodule

// *** sim/spi_port_monitor.sv ***
// checker for the spi port core, watching top-level ports only
// assumes it is bound into the core by the bench top
`timescale 1ns/100ps
`include "spi_port_regs.svh"
module spi_port_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire spi_port_pkg::pin_s sck,
  input wire spi_port_pkg::pin_s miso,
  input wire spi_port_pkg::pin_s ss_n,
  input wire logic spi_irq
);
  logic [15:0] cfg_m; // last config word written
  logic man_m; // last manual select bit written
  logic [2:0] ien_m; // last enables written
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // mirror of writable fields the pins depend on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_m <= `SPI_CFG_RST;
      man_m <= 1'h0;
      ien_m <= 3'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == {`SPI_IDX_CFG, 2'h0}) cfg_m <= pwdata[15:0];
      if (paddr == {`SPI_IDX_CTL, 2'h0}) man_m <= pwdata[`SPI_B_SSMAN];
      if (paddr == {`SPI_IDX_IEN, 2'h0}) ien_m <= pwdata[2:0];
    end
  end
  a_unmapped_err: assert property ( // register map
    psel && !penable && paddr == 18'h00000 |=> pslverr) else $error("unmapped not flagged");
  a_irq_gated: assert property (
    ien_m == 3'h0 && $past(ien_m) == 3'h0 |-> !spi_irq) else $error("irq with no enable");
  a_ss_manual: assert property (
    (sck.oe && cfg_m[4:0] == 5'h00 && $stable(man_m))[*3] |-> ss_n.o == !man_m)
    else $error("manual select level wrong");
  a_ss_float: assert property (
    (!cfg_m[5])[*2] |-> !ss_n.oe) else $error("select driven while disabled");
  a_shared_line: assert property (
    cfg_m[15][*2] |-> !miso.oe) else $error("miso driven in three-wire");
  a_lead_time: assert property (
    $fell(ss_n.o) && sck.oe && cfg_m[4:0] == 5'h01 && cfg_m[12:9] == 4'h0
    |=> $stable(sck.o)[*6]) else $error("clock before lead time");
  a_gap_time: assert property (
    $rose(ss_n.o) && sck.oe && cfg_m[4:0] == 5'h01 && cfg_m[12:9] == 4'h0
    |-> ss_n.o[*7]) else $error("select high time short");
  a_idle_level: assert property (
    (sck.oe && cfg_m[4:0] != 5'h00 && ss_n.o && $stable(cfg_m[13]))[*3]
    |-> sck.o == !cfg_m[13]) else $error("clock not at rest level");
  // main scenarios reached
  c_frame: cover property ($fell(ss_n.o) && sck.oe);
  c_irq: cover property ($rose(spi_irq));
  c_err: cover property (pslverr);
endmodule

// *** sim/tb.sv ***
// self-checking bench for the spi port core
// assumes core, checker and peer model are compiled before it
`timescale 1ns/100ps
`include "spi_port_regs.svh"
module tb;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [`SPI_ADDR_W-1:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  spi_port_pkg::pin_s sck;
  spi_port_pkg::pin_s mosi;
  spi_port_pkg::pin_s miso;
  spi_port_pkg::pin_s ss_n;
  logic spi_irq;
  logic idle_lvl = 1'h1; // peer's clock rest level
  logic lead_smp = 1'h0; // peer samples on leading edge
  logic [7:0] reply = 8'h00; // peer's answer byte
  logic peer_miso;
  logic [7:0] got; // bits the peer captured
  logic sck_w;
  logic ss_w;
  logic mosi_w;
  logic miso_w;
  logic [31:0] rd; // last read data
  logic err; // last error response
  int failures = 0;
  int comparisons = 0;
  // wire levels from every driver's enable; select pulled up
  assign sck_w = sck.oe ? sck.o : idle_lvl;
  assign ss_w = ss_n.oe ? ss_n.o : 1'h1;
  assign mosi_w = mosi.oe ? mosi.o : 1'h1;
  assign miso_w = miso.oe ? miso.o : peer_miso;
  always #2.5 core_clk = ~core_clk;
  spi_port_config_control dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .sck_i(sck_w), .mosi(mosi),
    .mosi_i(mosi_w), .miso(miso), .miso_i(miso_w), .ss_n(ss_n), .ss_n_i(ss_w),
    .spi_irq(spi_irq));
  spi_peer_model peer (.sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .idle_lvl(idle_lvl),
    .lead_smp(lead_smp), .reply(reply), .miso(peer_miso), .got(got));
  // one comparison, counted
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %08h expected %08h", $time, g, e);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // masked register read compare
  task automatic rchk(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, idx, 16'h0000);
    check(rd & m, e);
  endtask
  // poll until the engine is idle; the watchdog bounds it
  task automatic wait_idle();
    repeat (4) @(posedge core_clk);
    do apb(1'h0, `SPI_IDX_CFG, 16'h0000); while (rd[`SPI_B_BUSY] !== 1'h0);
  endtask
  // count clock pin changes over 200 cycles
  task automatic count_sck(output logic [31:0] t);
    logic last;
    t = 32'h0;
    last = sck.o;
    repeat (200) begin
      @(negedge core_clk);
      if (sck.o !== last) t++;
      last = sck.o;
    end
  endtask
  task automatic t_reset();
    rchk(`SPI_IDX_CFG, 32'hFFFF, 32'h801F);
    rchk(`SPI_IDX_CTL, 32'hFFFF, 32'h0380);
    rchk(`SPI_IDX_IEN, 32'hFFFF, 32'h0000);
  endtask
  task automatic t_regs();
    apb(1'h1, `SPI_IDX_IEN, 16'h0007);
    rchk(`SPI_IDX_IEN, 32'hFFFF, 32'h0007);
    apb(1'h1, 16'h0000, 16'hFFFF);
    check({31'h0, err}, 32'h1); // unmapped write refused
    apb(1'h1, `SPI_IDX_IEN, 16'h0000);
    apb(1'h1, `SPI_IDX_CTL, 16'h1000);
    rchk(`SPI_IDX_CTL, 32'h1000, 32'h0000);
    apb(1'h1, `SPI_IDX_CFG, 16'h0000);
    apb(1'h1, `SPI_IDX_CTL, 16'h1000);
    rchk(`SPI_IDX_CTL, 32'h1000, 32'h1000);
  endtask
  task automatic t_select();
    apb(1'h1, `SPI_IDX_CFG, 16'h0060);
    apb(1'h1, `SPI_IDX_CTL, 16'h1800);
    repeat (4) @(negedge core_clk);
    check({30'h0, ss_n.oe, ss_n.o}, 32'h2);
    apb(1'h1, `SPI_IDX_CTL, 16'h1000);
    repeat (4) @(negedge core_clk);
    check({30'h0, ss_n.oe, ss_n.o}, 32'h3);
    apb(1'h1, `SPI_IDX_CFG, 16'h0040);
    repeat (4) @(negedge core_clk);
    check({31'h0, ss_n.oe}, 32'h0);
  endtask
  task automatic t_strobe();
    logic [31:0] t;
    apb(1'h1, `SPI_IDX_CTL, 16'h9000);
    count_sck(t);
    check(t, 32'h10);
    rchk(`SPI_IDX_CTL, 32'h8000, 32'h0);
    apb(1'h1, `SPI_IDX_CFG, 16'h0000);
    apb(1'h1, `SPI_IDX_CTL, 16'h9000);
    count_sck(t);
    check(t, 32'h0);
  endtask
  // one byte-mode full duplex frame in the given mode and length
  task automatic t_xfer(input logic cpol, input logic adv, input logic [2:0] len,
    input logic [7:0] tx, input logic [7:0] rep);
    logic [3:0] n;
    logic [15:0] cfg;
    n = (len == 3'h0) ? 4'h8 : {1'h0, len};
    cfg = 16'h0061 | {2'h0, cpol, 13'h0} | {1'h0, adv, 14'h0};
    idle_lvl = ~cpol;
    lead_smp = adv;
    reply = rep;
    apb(1'h1, `SPI_IDX_CFG, cfg);
    apb(1'h1, `SPI_IDX_CTL, {10'h0C0, len, len});
    apb(1'h1, `SPI_IDX_IEN, 16'h0004);
    apb(1'h1, `SPI_IDX_DAT, {8'h00, tx});
    apb(1'h1, `SPI_IDX_CFG, cfg & 16'hFFBF);
    rchk(`SPI_IDX_CFG, 32'h00C0, 32'h00C0);
    while (spi_irq !== 1'h1) @(negedge core_clk);
    check({24'h0, got}, {24'h0, tx >> (4'h8 - n)});
    rchk(`SPI_IDX_DAT, 32'hFF, {24'h0, rep >> (4'h8 - n)});
    wait_idle();
    check({31'h0, spi_irq}, 32'h0);
  endtask
  task automatic t_fifo();
    apb(1'h1, `SPI_IDX_IEN, 16'h0000);
    apb(1'h1, `SPI_IDX_CFG, 16'h0000);
    apb(1'h1, `SPI_IDX_CTL, 16'h3000);
    repeat (4) apb(1'h1, `SPI_IDX_DAT, 16'h005A);
    rchk(`SPI_IDX_CTL, 32'h0280, 32'h0000);
    apb(1'h1, `SPI_IDX_CTL, 16'h7000);
    rchk(`SPI_IDX_CTL, 32'hC280, 32'h0280);
    apb(1'h1, `SPI_IDX_CFG, 16'h0061);
    repeat (5) begin
      apb(1'h1, `SPI_IDX_CTL, 16'h3400);
      wait_idle();
    end
    rchk(`SPI_IDX_CTL, 32'h04C0, 32'h00C0);
    rchk(`SPI_IDX_STS, 32'h0086, 32'h0086);
    apb(1'h1, `SPI_IDX_CLR, 16'h0002);
    rchk(`SPI_IDX_STS, 32'h0002, 32'h0000);
    check({31'h0, spi_irq}, 32'h0);
    apb(1'h1, `SPI_IDX_IEN, 16'h0004);
    repeat (3) @(negedge core_clk);
    check({31'h0, spi_irq}, 32'h1);
    apb(1'h1, `SPI_IDX_CTL, 16'h7000);
    rchk(`SPI_IDX_STS, 32'h0080, 32'h0000);
    rchk(`SPI_IDX_CTL, 32'h0040, 32'h0000);
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    t_reset();
    t_regs();
    t_select();
    t_strobe();
    for (int i = 0; i < 4; i++) t_xfer(i[1], i[0], 3'h0, 8'hA5, 8'h3C);
    t_xfer(1'h0, 1'h0, 3'h3, 8'hA5, 8'h3C);
    t_xfer(1'h1, 1'h1, 3'h7, 8'h96, 8'hC3);
    t_fifo();
    finish_test();
  end
endmodule
bind spi_port_config_control spi_port_monitor mon (.core_clk(core_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .sck(sck), .miso(miso), .ss_n(ss_n), .spi_irq(spi_irq));
